/* File: hw/qpt_top.sv */
// qpt_top: quad pot two-wire slave with wishbone control/status
// assumes: scl/sda/straps/write protect are asynchronous pins; sda is open drain
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
`include "qpt_map.svh"
module qpt_top #(
  parameter int unsigned TNV_CYC   = `QPT_TNV_CYC,
  parameter logic [3:0]  TYPE_CODE = `QPT_TYPE_CODE // arbitrary value
) (
  // system
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // wishbone slave
  input  wire qpt_pkg::qpt_wb_req_t wb_req,
  output qpt_pkg::qpt_wb_rsp_t      wb_rsp,
  // two-wire bus
  input  wire logic                 scl,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  // straps and write protect
  input  wire logic                 bus_addr_strap0,
  input  wire logic                 bus_addr_strap1,
  input  wire logic                 bus_addr_strap2,
  input  wire logic                 bus_addr_strap3,
  input  wire logic                 write_protect_n,
  // tap selects of the four pot channels
  output logic [3:0][7:0]           wiper_position_register
);
  import qpt_pkg::*;

  qpt_top_s_t r;
  qpt_top_s_t n;

  logic [`QPT_SY_W-1:0] sy_lvl;
  logic [`QPT_SY_W-1:0] sy_rise;
  logic [`QPT_SY_W-1:0] sy_fall;
  logic [15:0][7:0]     settings;
  logic                 nv_busy;
  logic                 scl_l;
  logic                 sda_l;
  logic                 scl_r;
  logic                 scl_f;
  logic                 start;
  logic                 stop;
  logic                 quiet;
  logic [3:0]           strap;
  logic [7:0]           own_id;
  qpt_op_t              op;
  logic                 is_rd;
  logic [7:0]           rd_byte;

  // straps are meant to be static, but still go through two flops
  qpt_sync u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .raw     ({bus_addr_strap3, bus_addr_strap2, bus_addr_strap1, bus_addr_strap0,
               write_protect_n, sda_i, scl}),
    .lvl     (sy_lvl),
    .rise    (sy_rise),
    .fall    (sy_fall)
  );

  qpt_nvm #(
    .TNV_CYC (TNV_CYC)
  ) u_nvm (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .req      (r.nv),
    .wp_n     (sy_lvl[`QPT_SY_WP]),
    .wiper    (wiper_position_register),
    .settings (settings),
    .busy     (nv_busy)
  );

  assign scl_l  = sy_lvl[`QPT_SY_SCL];
  assign sda_l  = sy_lvl[`QPT_SY_SDA];
  assign scl_r  = sy_rise[`QPT_SY_SCL];
  assign scl_f  = sy_fall[`QPT_SY_SCL];
  assign start  = scl_l && sy_fall[`QPT_SY_SDA];
  assign stop   = scl_l && sy_rise[`QPT_SY_SDA];
  // nonvolatile write in flight or slave disabled: the bus is not looked at
  assign quiet  = nv_busy || !r.en;
  assign strap  = sy_lvl[`QPT_SY_ST_HI:`QPT_SY_ST_LO];
  assign own_id = {TYPE_CODE, strap};
  assign op     = qpt_op_t'(r.inst[`QPT_OP_HI:`QPT_OP_LO]);
  assign is_rd  = (op == QPT_OP_RDW) || (op == QPT_OP_RDS);
  assign rd_byte = (op == QPT_OP_RDW) ?
                   wiper_position_register[r.inst[`QPT_CH_HI:`QPT_CH_LO]] :
                   settings[{r.inst[`QPT_CH_HI:`QPT_CH_LO], r.inst[`QPT_SLOT_HI:`QPT_SLOT_LO]}];

  always_comb begin
    n             = r;
    n.nv.wr_wiper = 1'b0;
    n.nv.wr_set   = 1'b0;
    // wishbone: registered answer, one cycle after the request
    n.ack = wb_req.cyc && wb_req.stb && !r.ack;
    if (n.ack) begin
      n.dat = `QPT_DAT_RST;
      case (wb_req.adr)
        `QPT_CTRL_OFS: begin
          n.dat[`QPT_CTRL_EN_BIT] = r.en;
          if (wb_req.we && wb_req.sel[0]) begin
            n.en = wb_req.dat[`QPT_CTRL_EN_BIT];
          end
        end
        `QPT_STAT_OFS: begin
          n.dat[`QPT_STAT_BUSY_BIT] = nv_busy;
          n.dat[`QPT_STAT_WP_BIT]   = sy_lvl[`QPT_SY_WP];
          n.dat[`QPT_STAT_ACT_BIT]  = (r.st != QPT_IDLE);
        end
        `QPT_WIPER_OFS: begin
          n.dat = wiper_position_register;
        end
        default: begin
          n.dat = `QPT_DAT_RST;
        end
      endcase
    end
    // two-wire slave
    if (quiet) begin
      n.st = QPT_IDLE;
      n.oe = 1'b0;
    end else if (start) begin
      n.st   = QPT_RX;
      n.kind = QPT_K_ID;
      n.bitn = `QPT_BIT_ZERO;
      n.oe   = 1'b0;
    end else if (stop) begin
      n.st   = QPT_IDLE;
      n.oe   = 1'b0;
      n.bitn = `QPT_BIT_ZERO;
      // the stored write starts only once the master has closed the frame
      if (r.pend) begin
        n.pend      = 1'b0;
        n.nv.wr_set = 1'b1;
        n.nv.ch     = r.inst[`QPT_CH_HI:`QPT_CH_LO];
        n.nv.slot   = r.inst[`QPT_SLOT_HI:`QPT_SLOT_LO];
        n.nv.data   = r.pdata;
      end
    end else begin
      case (r.st)
        QPT_RX: begin
          if (scl_r && r.bitn != `QPT_BYTE_BITS) begin
            n.sh   = {r.sh[6:0], sda_l};
            n.bitn = r.bitn + `QPT_BIT_ONE;
          end else if (scl_f && r.bitn == `QPT_BYTE_BITS) begin
            n.st = QPT_ACK;
            n.oe = 1'b1;
            case (r.kind)
              QPT_K_ID: begin
                if (r.sh != own_id) begin
                  n.st = QPT_IDLE;
                  n.oe = 1'b0;
                end
              end
              QPT_K_INST: begin
                n.inst = r.sh;
              end
              QPT_K_DATA: begin
                if (op == QPT_OP_WRW) begin
                  n.nv.wr_wiper = 1'b1;
                  n.nv.ch       = r.inst[`QPT_CH_HI:`QPT_CH_LO];
                  n.nv.data     = r.sh;
                end else if (op == QPT_OP_WRS) begin
                  n.pend  = 1'b1;
                  n.pdata = r.sh;
                end
              end
              default: begin
                n.st = QPT_IDLE;
                n.oe = 1'b0;
              end
            endcase
          end
        end
        QPT_ACK: begin
          if (scl_f) begin
            n.oe   = 1'b0;
            n.bitn = `QPT_BIT_ZERO;
            if (r.kind == QPT_K_INST && is_rd) begin
              n.st   = QPT_TX;
              n.sh   = rd_byte;
              n.oe   = !rd_byte[7];
              n.bitn = `QPT_BIT_ONE;
            end else begin
              n.st   = QPT_RX;
              n.kind = (r.kind == QPT_K_ID) ? QPT_K_INST : QPT_K_DATA;
            end
          end
        end
        QPT_TX: begin
          if (scl_f) begin
            if (r.bitn == `QPT_BYTE_BITS) begin
              n.st   = QPT_MACK;
              n.oe   = 1'b0;
              n.mack = 1'b0;
            end else begin
              n.sh   = {r.sh[6:0], 1'b0};
              n.oe   = !r.sh[6];
              n.bitn = r.bitn + `QPT_BIT_ONE;
            end
          end
        end
        QPT_MACK: begin
          if (scl_r) begin
            n.mack = !sda_l;
          end else if (scl_f) begin
            if (r.mack) begin
              n.st   = QPT_TX;
              n.sh   = rd_byte;
              n.oe   = !rd_byte[7];
              n.bitn = `QPT_BIT_ONE;
            end else begin
              n.st = QPT_IDLE;
            end
          end
        end
        default: begin
          n.st = QPT_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '{st: QPT_IDLE, kind: QPT_K_ID, en: `QPT_CTRL_RST, default: '0};
    end else begin
      r <= n;
    end
  end

  // open drain: only ever pull low
  assign sda_o      = 1'b0;
  assign sda_oe     = r.oe;
  assign wb_rsp.ack = r.ack;
  assign wb_rsp.dat = r.dat;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sda_after_fall_a: assert property ($changed(r.oe) |-> $past(scl_f || quiet || start || stop))
    else $error("sda drive changed without a falling scl edge");
  drive_low_only_a: assert property (sda_oe |-> (sda_o == 1'b0) && (r.st == QPT_ACK || r.st == QPT_TX))
    else $error("sda driven outside an ack or transmit phase");
  bit_capture_a: assert property ((r.st == QPT_RX && scl_r && r.bitn != `QPT_BYTE_BITS && !quiet && !start && !stop)
                                  |=> r.sh[0] == $past(sda_l) && r.bitn == $past(r.bitn) + `QPT_BIT_ONE)
    else $error("bit not captured on rising scl");
  id_match_a: assert property ((r.st == QPT_RX && r.kind == QPT_K_ID && r.bitn == `QPT_BYTE_BITS && scl_f &&
                                !quiet && !start && !stop) |=> ((r.st == QPT_ACK) == ($past(r.sh) == $past(own_id))))
    else $error("identification byte answered wrongly");
  id_code_a: assert property ((r.st == QPT_ACK && r.kind == QPT_K_ID) |-> r.sh[7:4] == TYPE_CODE && r.sh[3:0] == strap)
    else $error("acknowledged a foreign device type or strap");
  busy_silent_a: assert property (nv_busy |=> !sda_oe && r.st == QPT_IDLE)
    else $error("bus answered during a stored write");
  stop_idle_a: assert property ((stop && !quiet) |=> r.st == QPT_IDLE && !sda_oe && r.bitn == `QPT_BIT_ZERO)
    else $error("stop did not return the interface to idle");
  wiper_write_a: assert property (r.nv.wr_wiper |=>
                                  wiper_position_register[$past(r.nv.ch)] == $past(r.nv.data))
    else $error("wiper register did not take the written byte");
  wiper_hold_a: assert property ((!r.nv.wr_wiper && $past(!rst) && !$past(rst, 2)) |=>
                                 wiper_position_register == $past(wiper_position_register))
    else $error("wiper moved without a write");
  nv_launch_a: assert property ((stop && !quiet && r.pend) |=> r.nv.wr_set ##1 (nv_busy || !sy_lvl[`QPT_SY_WP]))
    else $error("stored write not started at stop");
  wb_ack_a: assert property ((wb_req.cyc && wb_req.stb && !wb_rsp.ack) |=> wb_rsp.ack ##1 !wb_rsp.ack)
    else $error("wishbone answer not one cycle after request");

  id_ack_cv: cover property (r.st == QPT_ACK && r.kind == QPT_K_ID);
  wip_wr_cv: cover property (r.nv.wr_wiper);
  rd_more_cv: cover property (r.st == QPT_MACK && scl_f && r.mack);
  id_miss_cv: cover property (r.st == QPT_RX && r.kind == QPT_K_ID && scl_f && r.bitn == `QPT_BYTE_BITS
                              && r.sh != own_id);
endmodule

/* File: pkg/qpt_map.svh */
// qpt_map.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from every qpt file that needs a figure
`ifndef QPT_MAP_SVH
`define QPT_MAP_SVH
// wishbone register byte offsets
`define QPT_CTRL_OFS      4'h0
`define QPT_STAT_OFS      4'h4
`define QPT_WIPER_OFS     4'h8
// register fields
`define QPT_CTRL_EN_BIT   0
`define QPT_STAT_BUSY_BIT 0
`define QPT_STAT_WP_BIT   1
`define QPT_STAT_ACT_BIT  2
`define QPT_CTRL_RST      1'h1
`define QPT_DAT_RST       32'h0
// device type field, arbitrary value
`define QPT_TYPE_CODE     4'hA
// instruction byte fields
`define QPT_OP_HI         7
`define QPT_OP_LO         6
`define QPT_SLOT_HI       3
`define QPT_SLOT_LO       2
`define QPT_CH_HI         1
`define QPT_CH_LO         0
// serial byte framing
`define QPT_BYTE_BITS     4'h8
`define QPT_BIT_ONE       4'h1
`define QPT_BIT_ZERO      4'h0
// setting storage contents after power-up
`define QPT_SET_RST       8'h80
// synchroniser lanes: scl, sda, write protect, four straps
`define QPT_SY_W          7
`define QPT_SY_SCL        0
`define QPT_SY_SDA        1
`define QPT_SY_WP         2
`define QPT_SY_ST_LO      3
`define QPT_SY_ST_HI      6
`define QPT_SYNC_RST      7'h7F
// nonvolatile write time
`define QPT_CLK_HZ        10000000
`define QPT_TNV_MS        10
`define QPT_TNV_CYC       ((`QPT_TNV_MS * `QPT_CLK_HZ) / 1000)
`define QPT_CNT_W         17
`endif

/* File: pkg/qpt_pkg.sv */
// qpt_pkg: types shared by the quad pot two-wire slave
// assumes: qpt_map.svh supplies every figure
package qpt_pkg;
  typedef enum logic [2:0] {
    QPT_IDLE = 3'b000,
    QPT_RX   = 3'b001,
    QPT_ACK  = 3'b010,
    QPT_TX   = 3'b011,
    QPT_MACK = 3'b100
  } qpt_state_t;
  typedef enum logic [1:0] {
    QPT_K_ID   = 2'b00,
    QPT_K_INST = 2'b01,
    QPT_K_DATA = 2'b10
  } qpt_kind_t;
  typedef enum logic [1:0] {
    QPT_OP_RDW = 2'b00,
    QPT_OP_WRW = 2'b01,
    QPT_OP_RDS = 2'b10,
    QPT_OP_WRS = 2'b11
  } qpt_op_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } qpt_wb_req_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } qpt_wb_rsp_t;
  typedef struct packed {
    logic       wr_wiper;
    logic       wr_set;
    logic [1:0] ch;
    logic [1:0] slot;
    logic [7:0] data;
  } qpt_nv_req_t;
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
  } qpt_sync_s_t;
  typedef struct packed {
    logic [3:0][7:0]  wip;
    logic [15:0][7:0] set;
    logic             recall;
    logic             busy;
    logic [16:0]      cnt;
  } qpt_nvm_s_t;
  typedef struct packed {
    qpt_state_t  st;
    qpt_kind_t   kind;
    logic [7:0]  sh;
    logic [3:0]  bitn;
    logic [7:0]  inst;
    logic [7:0]  pdata;
    logic        oe;
    logic        mack;
    logic        pend;
    qpt_nv_req_t nv;
    logic        en;
    logic        ack;
    logic [31:0] dat;
  } qpt_top_s_t;
endpackage

/* File: hw/qpt_sync.sv */
// qpt_sync: two-flop synchronisers for the pins, plus edge detection
// assumes: raw lanes are asynchronous to clk_sys
`timescale 1ns/10ps
`include "qpt_map.svh"
module qpt_sync (
  // system
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // pins and their clean images
  input  wire logic [`QPT_SY_W-1:0]   raw,
  output logic      [`QPT_SY_W-1:0]   lvl,
  output logic      [`QPT_SY_W-1:0]   rise,
  output logic      [`QPT_SY_W-1:0]   fall
);
  import qpt_pkg::*;
  qpt_sync_s_t r;
  qpt_sync_s_t n;

  // s1 is read only by s2; edges come from s2 against s3
  always_comb begin
    n    = r;
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '{default: `QPT_SYNC_RST};
    end else begin
      r <= n;
    end
  end

  assign lvl  = r.s2;
  assign rise = r.s2 & ~r.s3;
  assign fall = ~r.s2 & r.s3;
endmodule

/* File: hw/qpt_nvm.sv */
// qpt_nvm: wiper registers and setting storage with the nonvolatile write timer
// assumes: requests are one-cycle pulses on clk_sys; wp_n already synchronised
`timescale 1ns/10ps
`include "qpt_map.svh"
module qpt_nvm #(
  parameter int unsigned TNV_CYC = `QPT_TNV_CYC
) (
  // system
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // requests
  input  wire qpt_pkg::qpt_nv_req_t req,
  input  wire logic              wp_n,
  // state
  output logic [3:0][7:0]        wiper,
  output logic [15:0][7:0]       settings,
  output logic                   busy
);
  import qpt_pkg::*;
  qpt_nvm_s_t r;
  qpt_nvm_s_t n;

  always_comb begin
    n = r;
    if (r.recall) begin
      for (int c = 0; c < 4; c++) begin
        n.wip[c] = r.set[c*4];
      end
      n.recall = 1'b0;
    end else if (req.wr_wiper) begin
      n.wip[req.ch] = req.data;
    end
    if (r.busy) begin
      if (r.cnt == `QPT_CNT_W'(0)) begin
        n.busy = 1'b0;
      end else begin
        n.cnt = r.cnt - `QPT_CNT_W'(1);
      end
    end else if (req.wr_set && wp_n) begin
      n.set[{req.ch, req.slot}] = req.data;
      n.busy = 1'b1;
      n.cnt  = `QPT_CNT_W'(TNV_CYC - 1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '{set: {16{`QPT_SET_RST}}, recall: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign wiper    = r.wip;
  assign settings = r.set;
  assign busy     = r.busy;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  recall_copy_a: assert property ($past(rst) |=> r.wip == {r.set[12], r.set[8], r.set[4], r.set[0]})
    else $error("wipers not loaded from slot zero after reset");
  wp_block_a: assert property ((req.wr_set && !wp_n && !r.busy) |=> (r.set == $past(r.set)) && !r.busy)
    else $error("setting changed while write protected");
  nv_hold_a: assert property ($rose(r.busy) |-> r.cnt == `QPT_CNT_W'(TNV_CYC - 1))
    else $error("write timer not loaded with full count");
  nv_end_a: assert property ((r.busy && r.cnt == `QPT_CNT_W'(0)) |=> !r.busy)
    else $error("busy outlasted the write timer");
  set_cv: cover property (req.wr_set && wp_n && !r.busy);
endmodule

/* File: verif/qpt_tw_master.sv */
// qpt_tw_master: behavioural two-wire bus master for the bench
// assumes: sda is the resolved wire with a pull-up; one bit lasts 8 clk_sys cycles
`timescale 1ns/10ps
module qpt_tw_master (
  // system
  input  wire logic clk_sys,
  // two-wire bus
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // scl stands high between frames
  task automatic start();
    pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  // data set mid-low, sampled late in the high phase, clear of the slave's change after a fall
  task automatic bit_io(input logic b, output logic r);
    pull <= !b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    r = sda;
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!mack, r);
  endtask
  task automatic stop();
    pull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    pull <= 1'b0;
    tick(4);
  endtask
endmodule

/* File: verif/testbench.sv */
// testbench: self-checking bench for the quad pot two-wire slave
// assumes: qpt_tw_master drives the serial side; wishbone driven here
`timescale 1ns/10ps
`include "qpt_map.svh"
module testbench;
  import qpt_pkg::*;
  localparam logic [3:0] TC = 4'hA; // arbitrary device type value
  localparam logic [3:0] ST = 4'h5;
  localparam logic [7:0] SEL_B = {TC, ST};
  logic            clk_sys = 1'b0;
  logic            rst = 1'b1;
  qpt_wb_req_t     wb_req = '0;
  qpt_wb_rsp_t     wb_rsp;
  logic            scl;
  logic            pull;
  logic            sda_o;
  logic            sda_oe;
  logic            wp_n = 1'b1;
  logic [3:0]      strap = ST;
  logic [3:0][7:0] wpr;
  // open drain with pull-up: the pin only follows sda_o while its enable is high
  wire             sda_w = (sda_oe ? sda_o : 1'b1) && !pull;
  int              fails = 0;
  int              check_count = 0;
  always #50 clk_sys = ~clk_sys;
  qpt_top #(.TNV_CYC(400), .TYPE_CODE(TC)) dut (
    .clk_sys(clk_sys), .rst(rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .scl(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .bus_addr_strap0(strap[0]), .bus_addr_strap1(strap[1]),
    .bus_addr_strap2(strap[2]), .bus_addr_strap3(strap[3]), .write_protect_n(wp_n),
    .wiper_position_register(wpr));
  qpt_tw_master mst (.clk_sys(clk_sys), .sda(sda_w), .scl(scl), .pull(pull));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ack sampled at the rising edge; data taken and request released at that same edge
  task automatic wb_cyc(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
    do begin
      @(posedge clk_sys);
      n++;
      if (n > 20) begin
        fails++;
        test_done();
      end
    end while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wb_rd(input logic [3:0] a, output logic [31:0] d);
    wb_cyc(1'b0, a, 32'h0, d);
  endtask
  task automatic wb_wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb_cyc(1'b1, a, d, x);
  endtask
  task automatic head(input logic [7:0] sb, input logic [7:0] inst, output logic a);
    logic a1, a2;
    mst.start();
    mst.wbyte(sb, a1);
    a2 = 1'b0;
    if (a1) mst.wbyte(inst, a2);
    a = a1 & a2;
  endtask
  task automatic ser_wr(input logic [7:0] inst, input logic [7:0] d);
    logic a, a3;
    head(SEL_B, inst, a);
    mst.wbyte(d, a3);
    mst.stop();
    chk({a, a3}, 2'b11);
  endtask
  task automatic ser_rd(input logic [7:0] inst, output logic [7:0] d);
    logic a;
    logic [7:0] d2;
    head(SEL_B, inst, a);
    mst.rbyte(1'b1, d);
    mst.rbyte(1'b0, d2);
    mst.stop();
    chk({a, d2}, {1'b1, d});
  endtask
  task automatic t_reset();
    logic [31:0] d;
    chk(wpr, 32'h80808080);
    wb_rd(`QPT_WIPER_OFS, d);
    chk(d, 32'h80808080);
    wb_rd(`QPT_CTRL_OFS, d);
    chk(d, 32'h1);
    wb_rd(`QPT_STAT_OFS, d);
    chk(d, 32'h2);
    wb_rd(4'hC, d);
    chk(d, 32'h0);
  endtask
  task automatic t_wiper();
    logic [31:0] d;
    logic [7:0] d8;
    ser_wr(8'h42, 8'h3C);
    chk(wpr, 32'h803C8080);
    chk(sda_o, 1'b0);
    ser_wr(8'h43, 8'hFF);
    ser_wr(8'h40, 8'h00);
    chk(wpr, 32'hFF3C8000);
    ser_rd(8'h02, d8);
    chk(d8, 8'h3C);
    wb_rd(`QPT_WIPER_OFS, d);
    chk(d, 32'hFF3C8000);
  endtask
  task automatic t_addr();
    logic a;
    logic [3:0][7:0] bad;
    bad = {{TC, ST ^ 4'h1}, {TC, ST ^ 4'h8}, {TC ^ 4'h1, ST}, {~TC, ST}};
    for (int i = 0; i < 4; i++) begin
      head(bad[i], 8'h40, a);
      mst.stop();
      chk(a, 1'b0);
    end
    chk(wpr, 32'hFF3C8000);
  endtask
  task automatic t_stop();
    logic a, r;
    head(SEL_B, 8'h41, a);
    for (int i = 0; i < 4; i++) mst.bit_io(1'b0, r);
    mst.stop();
    chk(wpr, 32'hFF3C8000);
    ser_wr(8'h41, 8'h11);
    chk(wpr, 32'hFF3C1100);
  endtask
  task automatic t_store();
    logic [31:0] d;
    logic [7:0] d8;
    logic a;
    int n;
    ser_wr(8'hC4, 8'h5A);
    wb_rd(`QPT_STAT_OFS, d);
    chk(d[0], 1'b1);
    head(SEL_B, 8'h84, a);
    mst.stop();
    chk(a, 1'b0);
    n = 0;
    do begin
      wb_rd(`QPT_STAT_OFS, d);
      n++;
      if (n > 200) begin
        fails++;
        test_done();
      end
    end while (d[0] !== 1'b0);
    ser_rd(8'h84, d8);
    chk(d8, 8'h5A);
    chk(wpr, 32'hFF3C1100);
  endtask
  task automatic t_wp();
    logic [31:0] d;
    logic [7:0] d8;
    @(posedge clk_sys);
    wp_n <= 1'b0;
    ser_wr(8'hC9, 8'h77);
    wb_rd(`QPT_STAT_OFS, d);
    chk(d[1:0], 2'b00);
    @(posedge clk_sys);
    wp_n <= 1'b1;
    ser_rd(8'h89, d8);
    chk(d8, 8'h80);
  endtask
  task automatic t_en();
    logic [31:0] d;
    logic a;
    wb_wr(`QPT_CTRL_OFS, 32'h0);
    head(SEL_B, 8'h40, a);
    mst.stop();
    chk(a, 1'b0);
    wb_wr(`QPT_CTRL_OFS, 32'h1);
    wb_rd(`QPT_CTRL_OFS, d);
    chk(d, 32'h1);
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    t_reset();
    t_wiper();
    t_addr();
    t_stop();
    t_store();
    t_wp();
    t_en();
    test_done();
  end
endmodule
